// *** vtc_pkg.sv ***
// vtc_pkg: constants and types for the vicinity tag response coder.
// assumes a single system clock domain; carrier and field pins are synchronised in the top.
package vtc_pkg;

  // carrier-cycle timing of the response, high data rate
  localparam int HALF_SUB1 = 16; // half period of the 423.75 khz subcarrier
  localparam int HALF_SUB2 = 14; // half period of the 484.28 khz subcarrier
  localparam int PAIRS_BIT_SUB1 = 8;
  localparam int PAIRS_BIT_SUB2 = 9;
  localparam int PAIRS_FRM_SUB1 = 24;
  localparam int PAIRS_FRM_SUB2 = 27;
  localparam int GAP_BIT_CYC = 256;
  localparam int GAP_FRM_CYC = 768;
  localparam int PAIRS_GAP_BIT = GAP_BIT_CYC / (2 * HALF_SUB1);
  localparam int PAIRS_GAP_FRM = GAP_FRM_CYC / (2 * HALF_SUB1);
  localparam int LOW_RATE_MUL = 4;

  // request eof to response sof, in carrier cycles
  localparam int T1_MIN_CYC = 4320;
  localparam int T1_NOM_CYC = 4352;
  localparam int T1_MAX_CYC = 4384;

  // crc-16, reflected form, preset all ones, sent inverted
  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;

  // network command codes
  localparam logic [7:0] CMD_STAY_QUIET = 8'h02;
  localparam logic [7:0] CMD_SELECT = 8'h25;
  localparam logic [7:0] CMD_RESET_READY = 8'h26;

  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08; // first word of the tx byte buffer
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_LEN_LSB = 8;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_RESP_BIT = 3;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {TAG_OFF, TAG_READY, TAG_QUIET, TAG_SELECTED} vtc_tag_state_t;
  typedef enum logic [2:0] {SYM_ZERO, SYM_ONE, SYM_SOF, SYM_EOF} vtc_sym_t;
  typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_SOF, TX_SOF1, TX_DATA, TX_EOF0, TX_EOF}
    vtc_tx_phase_t;

  // decoded request, one-cycle valid from the command parser
  typedef struct packed {
    logic valid;
    logic sub2;       // two subcarriers requested
    logic high_rate;  // high data rate requested
    logic uid_flag;
    logic sel_flag;
    logic uid_match;  // uid field present and equal to our uid
    logic [7:0] cmd;
  } vtc_req_t;

  // one segment of a symbol: pairs of on/off halves, or silent pairs
  typedef struct packed {
    logic [4:0] pairs;
    logic [6:0] half;
    logic act;
  } vtc_seg_t;

endpackage : vtc_pkg

// *** vtc_coder.sv ***
// vtc_coder: tag state keeping, response decision and response frame encoder.
// assumes the parser delivers one vtc_req_t pulse at each request eof, on clk_sys;
// carrier, field and pause pins are asynchronous and pass two flip-flops here.
//
// Our own choices: register access over AXI4-Lite and the address map.
module vtc_coder
  import vtc_pkg::*;
#(
  parameter int T1_CYC = T1_NOM_CYC,
  parameter int TXBUF_BYTES = 8,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // rf front end pins
  input wire logic carrier_clk,
  input wire logic field_on,
  input wire logic pause_det,
  output logic mod_q,
  output logic sc_high_q,
  // decoded request from the parser
  input wire vtc_req_t req,
  output logic resp_go_q,
  output logic tx_busy_q,
  output vtc_tag_state_t tag_state_q,
  // axi4-lite register slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int TXW = TXBUF_BYTES / 4;
  localparam int BI_W = $clog2(TXBUF_BYTES + 3);

  // segment table, low rate stretches each half by four
  function automatic vtc_seg_t seg_get(vtc_sym_t s, logic sub2, logic low, logic idx);
    vtc_seg_t r;
    logic [6:0] h16;
    logic [6:0] h14;
    h16 = low ? 7'(HALF_SUB1 * LOW_RATE_MUL) : 7'(HALF_SUB1);
    h14 = low ? 7'(HALF_SUB2 * LOW_RATE_MUL) : 7'(HALF_SUB2);
    r = '{pairs: 5'(PAIRS_BIT_SUB1), half: h16, act: 1'b1};
    case (s)
      SYM_ZERO:
      begin
        if (sub2)
          r = idx ? '{5'(PAIRS_BIT_SUB2), h14, 1'b1} : '{5'(PAIRS_BIT_SUB1), h16, 1'b1};
        else
          r = idx ? '{5'(PAIRS_GAP_BIT), h16, 1'b0} : '{5'(PAIRS_BIT_SUB1), h16, 1'b1};
      end
      SYM_ONE:
      begin
        if (sub2)
          r = idx ? '{5'(PAIRS_BIT_SUB1), h16, 1'b1} : '{5'(PAIRS_BIT_SUB2), h14, 1'b1};
        else
          r = idx ? '{5'(PAIRS_BIT_SUB1), h16, 1'b1} : '{5'(PAIRS_GAP_BIT), h16, 1'b0};
      end
      SYM_SOF:
      begin
        if (sub2)
          r = idx ? '{5'(PAIRS_FRM_SUB1), h16, 1'b1} : '{5'(PAIRS_FRM_SUB2), h14, 1'b1};
        else
          r = idx ? '{5'(PAIRS_FRM_SUB1), h16, 1'b1} : '{5'(PAIRS_GAP_FRM), h16, 1'b0};
      end
      SYM_EOF:
      begin
        if (sub2)
          r = idx ? '{5'(PAIRS_FRM_SUB2), h14, 1'b1} : '{5'(PAIRS_FRM_SUB1), h16, 1'b1};
        else
          r = idx ? '{5'(PAIRS_GAP_FRM), h16, 1'b0} : '{5'(PAIRS_FRM_SUB1), h16, 1'b1};
      end
      default: r = '{5'(PAIRS_BIT_SUB1), h16, 1'b1};
    endcase
    return r;
  endfunction

  // one bit of the reflected crc-16
  function automatic logic [15:0] crc_step(logic [15:0] c, logic b);
    logic fb;
    fb = c[0] ^ b;
    return fb ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
  endfunction

  // pin synchronisers; stage one feeds only stage two
  logic car_s1_q, car_s2_q, car_s3_q;
  logic fld_s1_q, fld_s2_q;
  logic pau_s1_q, pau_s2_q, pau_s3_q;
  logic car_tick;
  logic pause_edge;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      {car_s1_q, car_s2_q, car_s3_q} <= 3'h0;
      {fld_s1_q, fld_s2_q} <= 2'h0;
      {pau_s1_q, pau_s2_q, pau_s3_q} <= 3'h0;
    end
    else
    begin
      {car_s1_q, car_s2_q, car_s3_q} <= {carrier_clk, car_s1_q, car_s2_q};
      {fld_s1_q, fld_s2_q} <= {field_on, fld_s1_q};
      {pau_s1_q, pau_s2_q, pau_s3_q} <= {pause_det, pau_s1_q, pau_s2_q};
    end
  end

  // every carrier rising edge is one counting step
  assign car_tick = car_s2_q & ~car_s3_q;
  assign pause_edge = pau_s2_q & ~pau_s3_q;

  // register file
  logic [31:0] ctrl_q;
  logic [7:0] txbuf_q [TXBUF_BYTES];
  logic last_resp_q;

  // address mode decode
  logic m_nonaddr, m_addr, m_sel, processed, respond;
  logic is_quiet_cmd, is_sel_cmd, is_rtr_cmd;

  assign m_nonaddr = ~req.uid_flag & ~req.sel_flag;
  assign m_addr = req.uid_flag & ~req.sel_flag & req.uid_match;
  assign m_sel = ~req.uid_flag & req.sel_flag;
  assign is_quiet_cmd = req.cmd == CMD_STAY_QUIET;
  assign is_sel_cmd = req.cmd == CMD_SELECT;
  assign is_rtr_cmd = req.cmd == CMD_RESET_READY;

  // which requests this state handles at all
  always_comb
  begin
    case (tag_state_q)
      TAG_READY: processed = m_nonaddr | m_addr;
      TAG_QUIET: processed = m_addr;
      TAG_SELECTED: processed = m_nonaddr | m_addr | m_sel;
      default: processed = 1'b0;
    endcase
  end

  // a foreign select is not answered, stay quiet never is
  assign respond = req.valid & fld_s2_q & processed & ~is_quiet_cmd
    & ~(is_sel_cmd & ~m_addr);

  // tag state machine
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      tag_state_q <= TAG_OFF;
    else if (!fld_s2_q)
      tag_state_q <= TAG_OFF;
    else
    begin
      case (tag_state_q)
        TAG_OFF: tag_state_q <= TAG_READY;
        TAG_READY:
        begin
          if (req.valid && m_addr && is_quiet_cmd)
            tag_state_q <= TAG_QUIET;
          else if (req.valid && m_addr && is_sel_cmd)
            tag_state_q <= TAG_SELECTED;
        end
        TAG_QUIET:
        begin
          if (req.valid && (m_nonaddr || m_addr) && is_rtr_cmd)
            tag_state_q <= TAG_READY;
          else if (req.valid && m_addr && is_sel_cmd)
            tag_state_q <= TAG_SELECTED;
        end
        TAG_SELECTED:
        begin
          if (req.valid && (m_nonaddr || m_addr) && is_rtr_cmd)
            tag_state_q <= TAG_READY;
          else if (req.valid && m_addr && is_quiet_cmd)
            tag_state_q <= TAG_QUIET;
          else if (req.valid && is_sel_cmd && req.uid_flag && !req.uid_match)
            tag_state_q <= TAG_READY;
        end
        default: tag_state_q <= TAG_OFF;
      endcase
    end
  end

  // transmit engine state
  vtc_tx_phase_t ph_q;
  logic sub2_q, low_q;
  logic [12:0] t1_q;
  logic idx_q, hlf_q;
  logic [4:0] pr_q;
  logic [6:0] cyc_q;
  logic [BI_W-1:0] byte_q;
  logic [2:0] bit_q;
  logic [15:0] crc_q;
  logic [BI_W-1:0] len;
  logic cur_bit, sym_done, data_last;
  vtc_sym_t cur_sym;
  vtc_seg_t seg;

  assign len = (ctrl_q[CTRL_LEN_LSB +: 4] > 4'(TXBUF_BYTES)) ? BI_W'(TXBUF_BYTES)
    : BI_W'(ctrl_q[CTRL_LEN_LSB +: 4]);

  // payload bits, then the inverted crc, low bit first
  always_comb
  begin
    if (byte_q < len)
      cur_bit = txbuf_q[byte_q[$clog2(TXBUF_BYTES)-1:0]][bit_q];
    else if (byte_q == len)
      cur_bit = ~crc_q[bit_q];
    else
      cur_bit = ~crc_q[{1'b1, bit_q}];
  end

  always_comb
  begin
    case (ph_q)
      TX_SOF: cur_sym = SYM_SOF;
      TX_SOF1: cur_sym = SYM_ONE;
      TX_DATA: cur_sym = cur_bit ? SYM_ONE : SYM_ZERO;
      TX_EOF0: cur_sym = SYM_ZERO;
      TX_EOF: cur_sym = SYM_EOF;
      default: cur_sym = SYM_ZERO;
    endcase
  end

  assign seg = seg_get(cur_sym, sub2_q, low_q, idx_q);
  assign sym_done = car_tick && cyc_q == seg.half - 7'h1 && hlf_q
    && pr_q == seg.pairs - 5'h1 && idx_q;
  assign data_last = byte_q == len + BI_W'(1) && bit_q == 3'h7;

  // phase sequencing, t1 wait restarts on a full-depth pause
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ph_q <= TX_IDLE;
      t1_q <= 13'h0;
      sub2_q <= 1'b0;
      low_q <= 1'b0;
    end
    else if (!fld_s2_q)
      ph_q <= TX_IDLE;
    else
    begin
      case (ph_q)
        TX_IDLE:
        begin
          if (respond && ctrl_q[CTRL_EN_BIT])
          begin
            ph_q <= TX_WAIT;
            t1_q <= 13'h0;
            sub2_q <= req.sub2;
            low_q <= ~req.high_rate;
          end
        end
        TX_WAIT:
        begin
          if (pause_edge)
            t1_q <= 13'h0;
          else if (car_tick && t1_q == 13'(T1_CYC - 1))
            ph_q <= TX_SOF;
          else if (car_tick)
            t1_q <= t1_q + 13'h1;
        end
        TX_SOF: if (sym_done) ph_q <= TX_SOF1;
        TX_SOF1: if (sym_done) ph_q <= TX_DATA;
        TX_DATA: if (sym_done && data_last) ph_q <= TX_EOF0;
        TX_EOF0: if (sym_done) ph_q <= TX_EOF;
        TX_EOF: if (sym_done) ph_q <= TX_IDLE;
        default: ph_q <= TX_IDLE;
      endcase
    end
  end

  // half, pair and segment counters run on carrier ticks
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cyc_q <= 7'h0;
      hlf_q <= 1'b0;
      pr_q <= 5'h0;
      idx_q <= 1'b0;
    end
    else if (ph_q == TX_IDLE || ph_q == TX_WAIT)
    begin
      cyc_q <= 7'h0;
      hlf_q <= 1'b0;
      pr_q <= 5'h0;
      idx_q <= 1'b0;
    end
    else if (car_tick)
    begin
      if (cyc_q != seg.half - 7'h1)
        cyc_q <= cyc_q + 7'h1;
      else
      begin
        cyc_q <= 7'h0;
        hlf_q <= ~hlf_q;
        if (hlf_q)
        begin
          if (pr_q != seg.pairs - 5'h1)
            pr_q <= pr_q + 5'h1;
          else
          begin
            pr_q <= 5'h0;
            idx_q <= ~idx_q;
          end
        end
      end
    end
  end

  // bit pointer and running crc over the payload
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      byte_q <= '0;
      bit_q <= 3'h0;
      crc_q <= CRC_PRESET;
    end
    else if (ph_q == TX_IDLE)
    begin
      byte_q <= '0;
      bit_q <= 3'h0;
      crc_q <= CRC_PRESET;
    end
    else if (ph_q == TX_DATA && sym_done)
    begin
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7)
        byte_q <= byte_q + BI_W'(1);
      if (byte_q < len)
        crc_q <= crc_step(crc_q, cur_bit);
    end
  end

  // pin outputs; silent whenever no frame symbol is on air
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mod_q <= 1'b0;
      sc_high_q <= 1'b0;
      tx_busy_q <= 1'b0;
      resp_go_q <= 1'b0;
      last_resp_q <= 1'b0;
    end
    else
    begin
      mod_q <= ph_q inside {TX_SOF, TX_SOF1, TX_DATA, TX_EOF0, TX_EOF}
        && seg.act && !hlf_q;
      sc_high_q <= ph_q inside {TX_SOF, TX_SOF1, TX_DATA, TX_EOF0, TX_EOF}
        && sub2_q && seg.half == (low_q ? 7'(HALF_SUB2 * LOW_RATE_MUL) : 7'(HALF_SUB2));
      tx_busy_q <= ph_q != TX_IDLE;
      resp_go_q <= respond;
      if (req.valid)
        last_resp_q <= respond;
    end
  end

  // axi4-lite write: address and data taken in either order
  logic aw_q, w_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_hit;

  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_q & ~s_axi_bvalid;

  always_comb
  begin
    wr_hit = awaddr_q == ADDR_W'(REG_CTRL);
    for (int k = 0; k < TXW; k++)
      if (awaddr_q == ADDR_W'(REG_TXDATA + 4 * k))
        wr_hit = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_q && w_q && !s_axi_bvalid)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // register storage, byte strobes honoured
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= CTRL_RST;
      for (int i = 0; i < TXBUF_BYTES; i++)
        txbuf_q[i] <= 8'h00;
    end
    else if (aw_q && w_q && !s_axi_bvalid)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wstrb_q[b] && awaddr_q == ADDR_W'(REG_CTRL))
          ctrl_q[8*b +: 8] <= wdata_q[8*b +: 8];
        for (int k = 0; k < TXW; k++)
          if (wstrb_q[b] && awaddr_q == ADDR_W'(REG_TXDATA + 4 * k))
            txbuf_q[4*k + b] <= wdata_q[8*b +: 8];
      end
    end
  end

  // axi4-lite read, answered one edge after the address is taken
  logic [31:0] rd_mux;
  logic rd_hit;

  always_comb
  begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    if (s_axi_araddr == ADDR_W'(REG_CTRL))
      rd_mux = ctrl_q;
    else if (s_axi_araddr == ADDR_W'(REG_STATUS))
      rd_mux = {28'h0, last_resp_q, tx_busy_q, tag_state_q};
    else
    begin
      rd_hit = 1'b0;
      for (int k = 0; k < TXW; k++)
        if (s_axi_araddr == ADDR_W'(REG_TXDATA + 4 * k))
        begin
          rd_hit = 1'b1;
          rd_mux = {txbuf_q[4*k+3], txbuf_q[4*k+2], txbuf_q[4*k+1], txbuf_q[4*k]};
        end
    end
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // vtc_coder

// *** vtc_coder_chk.sv ***
// vtc_coder_chk: concurrent checks on the ports of the response coder.
// assumes one clk_sys domain and rst active high; bound into every vtc_coder.
module vtc_coder_chk
  import vtc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // rf side
  input wire logic field_on,
  input wire logic pause_det,
  input wire logic mod_q,
  input wire logic sc_high_q,
  // request and decision
  input wire vtc_req_t req,
  input wire logic resp_go_q,
  input wire logic tx_busy_q,
  input wire vtc_tag_state_t tag_state_q,
  // register read channel
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // network commands are left out: stay quiet and select do not answer in every mode
  logic plain_cmd;
  assign plain_cmd = req.cmd != CMD_STAY_QUIET && req.cmd != CMD_SELECT
    && req.cmd != CMD_RESET_READY;

  AST_IDLE_QUIET: assert property ((!tx_busy_q) [*2] |-> !mod_q)
    else $error("modulation outside a frame");
  AST_GO_CAUSE: assert property (resp_go_q |-> $past(req.valid))
    else $error("response decision without a request");
  AST_OFF_SILENT: assert property (req.valid && tag_state_q == TAG_OFF |=> !resp_go_q)
    else $error("powered-off tag answered");
  AST_NO_QUIET_REPLY: assert property (req.valid && req.cmd == CMD_STAY_QUIET |=> !resp_go_q)
    else $error("stay quiet answered");
  AST_QUIET_ADDR_ONLY: assert property (req.valid && tag_state_q == TAG_QUIET && !req.uid_flag
    |=> !resp_go_q && (tag_state_q == TAG_QUIET || $past(req.cmd) == CMD_RESET_READY))
    else $error("quiet tag processed an unaddressed request");
  AST_READY_SELMODE: assert property (req.valid && tag_state_q == TAG_READY && req.sel_flag
    && !req.uid_flag |=> !resp_go_q && tag_state_q == TAG_READY)
    else $error("ready tag answered select mode");
  AST_SEL_ALL: assert property (req.valid && tag_state_q == TAG_SELECTED && plain_cmd
    && !(req.uid_flag && req.sel_flag) && (!req.uid_flag || req.uid_match) |=> resp_go_q)
    else $error("selected tag ignored a request");
  AST_TO_QUIET: assert property (req.valid && tag_state_q == TAG_READY
    && req.cmd == CMD_STAY_QUIET && req.uid_flag && !req.sel_flag && req.uid_match
    |=> tag_state_q == TAG_QUIET)
    else $error("addressed stay quiet not taken");
  AST_FOREIGN_SEL: assert property (req.valid && tag_state_q == TAG_SELECTED
    && req.cmd == CMD_SELECT && req.uid_flag && !req.sel_flag && !req.uid_match
    |=> tag_state_q == TAG_READY)
    else $error("foreign select kept the tag selected");
  AST_FIELD_LOSS: assert property ((!field_on) [*5] |-> tag_state_q == TAG_OFF && !mod_q)
    else $error("tag alive without field");
  AST_POWER_UP: assert property (field_on [*5] |-> tag_state_q != TAG_OFF)
    else $error("tag not ready in the field");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");

  // main scenarios reached
  cover property (resp_go_q);
  cover property (tag_state_q == TAG_QUIET);
  cover property (mod_q && sc_high_q);
  cover property ($rose(pause_det) && tx_busy_q);
endmodule // vtc_coder_chk

bind vtc_coder vtc_coder_chk vtc_coder_chk_inst (
  .clk_sys, .rst, .field_on, .pause_det, .mod_q, .sc_high_q, .req, .resp_go_q,
  .tx_busy_q, .tag_state_q, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);

// *** vtc_reader_model.sv ***
// vtc_reader_model: reader side of the rf link for the coder bench.
// assumes clk_sys from the bench; mod_q is sampled at carrier rising edges only.
module vtc_reader_model
  import vtc_pkg::*;
(
  // bench clock and tag load modulation
  input wire logic clk_sys,
  input wire logic mod_q,
  // field, carrier and decoded request toward the tag
  output logic carrier_clk,
  output logic field_on,
  output logic pause_det,
  output vtc_req_t req
);
  timeunit 1ns;
  timeprecision 100ps;
  int runs [256];

  // field present from the start, nothing requested
  initial
  begin
    carrier_clk = 1'b0;
    field_on = 1'b1;
    pause_det = 1'b0;
    req = '0;
  end

  // carrier exists only while the field is up, so a lost field gives no edges
  always #100 carrier_clk = field_on ? ~carrier_clk : 1'b0;

  // one decoded request at the reader eof, held for one clk_sys cycle
  task automatic send(input logic s2, hi, u, s, m, input logic [7:0] c);
    @(posedge clk_sys);
    req <= {1'b1, s2, hi, u, s, m, c};
    @(posedge clk_sys);
    req <= '0;
  endtask

  // full-depth pause, long enough to pass the tag synchroniser
  task automatic pulse();
    @(posedge clk_sys);
    pause_det <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pause_det <= 1'b0;
  endtask

  // field up or down
  task automatic power(input logic on);
    @(posedge clk_sys);
    field_on <= on;
  endtask

  // run lengths from the first modulated cycle on; ld counts the silence before it plus that first modulated cycle
  task automatic grab(input int n, output int got, output int ld);
    int len;
    int g;
    logic lvl;
    got = 0;
    len = 0;
    ld = 0;
    lvl = 1'b0;
    for (g = 0; got < n && g < 4000; g++)
    begin
      @(posedge carrier_clk);
      if (len == 0)
        ld++;
      if (mod_q !== lvl)
      begin
        if (len > 0)
          runs[got++] = len;
        lvl = mod_q;
        len = 1;
      end
      else if (len > 0)
        len++;
    end
  endtask
endmodule // vtc_reader_model

// *** tb_top.sv ***
// tb_top: self-checking bench for vtc_coder with a reader model on the rf side.
// assumes vtc_pkg; registers are reached only through the axi task.
module tb_top
  import vtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int T1 = 40;
  localparam logic [7:0] CMD_OTHER = 8'h20;
  localparam logic [7:0] TX_BYTE = 8'hfe;
  logic clk_sys, rst, carrier_clk, field_on, pause_det, mod_q, sc_high_q, resp_go_q, tx_busy_q;
  vtc_req_t req;
  vtc_tag_state_t tag_state_q;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int failures, compares;

  // 40 mhz system clock
  always #12.5 clk_sys = ~clk_sys;

  vtc_coder #(.T1_CYC(T1)) vtc_coder_inst (
    .clk_sys(clk_sys), .rst(rst), .carrier_clk(carrier_clk), .field_on(field_on),
    .pause_det(pause_det), .mod_q(mod_q), .sc_high_q(sc_high_q), .req(req),
    .resp_go_q(resp_go_q), .tx_busy_q(tx_busy_q), .tag_state_q(tag_state_q),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  vtc_reader_model vtc_reader_model_inst (
    .clk_sys(clk_sys), .mod_q(mod_q), .carrier_clk(carrier_clk), .field_on(field_on),
    .pause_det(pause_det), .req(req)
  );

  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one axi4-lite access; an edge passes first, the answer is taken at the handshake edge
  task automatic axi(input logic we, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic [1:0] rs);
    int n;
    logic hs, pa, pw;
    hs = 1'b0;
    @(posedge clk_sys);
    if (we)
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    else
      {araddr, arvalid, rready} <= {a, 2'h3};
    for (n = 0; n < 200 && !hs; n++)
    begin
      @(posedge clk_sys);
      hs = we ? bvalid : rvalid;
      pa = we ? awvalid && awready : arvalid && arready;
      pw = wvalid && wready;
      q = rdata;
      rs = we ? bresp : rresp;
      if (pa)
        {awvalid, arvalid} <= 2'h0;
      if (pw)
        wvalid <= 1'b0;
      if (hs)
        {bready, rready} <= 2'h0;
    end
    if (!hs)
    begin
      failures++;
      report_and_stop();
    end
  endtask

  // one request, then the status word: {decision, busy, state} under a mask
  task automatic step(input logic [7:0] c, input logic u, s, m, input logic [3:0] e, k);
    logic [31:0] q;
    logic [1:0] rs;
    vtc_reader_model_inst.send(1'b0, 1'b1, u, s, m, c);
    repeat (4) @(posedge clk_sys);
    axi(1'b0, REG_STATUS, 32'h0, q, rs);
    chk("status", {28'h0, e & k}, q & {28'h0, k});
  endtask

  // expected length of run k, counted from the first modulated carrier cycle
  function automatic int exp_run(input logic s2, hi, input int k);
    int m;
    int p;
    m = hi ? 1 : LOW_RATE_MUL;
    p = k / 2;
    if (s2)
      return m * ((p < PAIRS_FRM_SUB2 || p >= PAIRS_FRM_SUB2 + PAIRS_FRM_SUB1) ?
        HALF_SUB2 : HALF_SUB1);
    if (k % 2 == 1 && (p == PAIRS_FRM_SUB1 - 1 ||
      (p == PAIRS_FRM_SUB1 + PAIRS_BIT_SUB1 - 1 && TX_BYTE[0])))
      return m * (HALF_SUB1 + GAP_BIT_CYC);
    return m * HALF_SUB1;
  endfunction

  // frame start measured on air, then aborted by field loss to keep the run short
  task automatic frame(input logic s2, hi, pz, input int lead, n);
    int got;
    int ld;
    vtc_reader_model_inst.send(s2, hi, 1'b0, 1'b0, 1'b0, CMD_OTHER);
    fork
      vtc_reader_model_inst.grab(n, got, ld);
      if (pz)
      begin
        repeat (20) @(posedge carrier_clk);
        vtc_reader_model_inst.pulse();
      end
    join
    chk("runs", n, got);
    chk("sc high", s2 & ~hi, sc_high_q);
    chk("lead", 1, ld >= lead - 4 && ld <= lead + 4);
    for (int k = 0; k < got; k++)
      chk("run", exp_run(s2, hi, k), vtc_reader_model_inst.runs[k]);
    vtc_reader_model_inst.power(1'b0);
    repeat (6) @(posedge clk_sys);
    chk("mod off", 0, mod_q);
    chk("state off", TAG_OFF, tag_state_q);
    vtc_reader_model_inst.power(1'b1);
    repeat (6) @(posedge clk_sys);
    chk("state up", TAG_READY, tag_state_q);
    $display("frame test done sub2 %0d high %0d", s2, hi);
  endtask

  initial
  begin
    logic [31:0] q;
    logic [1:0] rs;
    {clk_sys, rst, awvalid, wvalid, bready, arvalid, rready} = 7'h20;
    {awaddr, araddr, wdata, wstrb} = {48'h0, 4'hf};
    failures = 0;
    compares = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("power up", TAG_READY, tag_state_q);
    axi(1'b0, REG_CTRL, 32'h0, q, rs);
    chk("ctrl reset", CTRL_RST, q);
    axi(1'b1, REG_CTRL, 32'h0, q, rs);
    chk("ctrl write", AXI_OKAY, rs);
    axi(1'b0, 8'h40, 32'h0, q, rs);
    chk("unmapped read", 32'h0, q);
    chk("unmapped rresp", AXI_SLVERR, rs);
    axi(1'b1, 8'h40, 32'h1, q, rs);
    chk("unmapped write", AXI_SLVERR, rs);
    axi(1'b1, REG_TXDATA, {24'h0, TX_BYTE}, q, rs);
    axi(1'b0, REG_TXDATA, 32'h0, q, rs);
    chk("txdata", {24'h0, TX_BYTE}, q);
    $display("register test done");
    step(CMD_OTHER, 0, 0, 0, 4'h9, 4'hf);
    step(CMD_OTHER, 0, 1, 0, 4'h1, 4'hf);
    step(CMD_OTHER, 1, 0, 1, 4'h9, 4'hf);
    step(CMD_STAY_QUIET, 1, 0, 0, 4'h1, 4'hf);
    step(CMD_STAY_QUIET, 0, 0, 0, 4'h1, 4'hf);
    step(CMD_STAY_QUIET, 1, 0, 1, 4'h2, 4'hf);
    step(CMD_OTHER, 0, 0, 0, 4'h2, 4'hf);
    step(CMD_OTHER, 0, 1, 0, 4'h2, 4'hf);
    step(CMD_OTHER, 1, 0, 1, 4'ha, 4'hf);
    step(CMD_RESET_READY, 0, 0, 0, 4'h1, 4'h7);
    step(CMD_SELECT, 1, 0, 0, 4'h1, 4'hf);
    step(CMD_SELECT, 1, 0, 1, 4'hb, 4'hf);
    step(CMD_OTHER, 0, 1, 0, 4'hb, 4'hf);
    step(CMD_STAY_QUIET, 1, 0, 1, 4'h2, 4'hf);
    step(CMD_SELECT, 1, 0, 1, 4'hb, 4'hf);
    step(CMD_SELECT, 1, 0, 0, 4'h1, 4'h7);
    step(CMD_SELECT, 1, 0, 1, 4'hb, 4'hf);
    step(CMD_RESET_READY, 0, 0, 0, 4'h9, 4'hf);
    $display("state test done");
    axi(1'b1, REG_CTRL, 32'h0000_0101, q, rs);
    frame(1'b0, 1'b1, 1'b0, T1 + GAP_FRM_CYC, 64);
    frame(1'b1, 1'b1, 1'b1, T1 + 20, 120);
    frame(1'b0, 1'b0, 1'b0, T1 + GAP_FRM_CYC * LOW_RATE_MUL, 8);
    frame(1'b1, 1'b0, 1'b0, T1, 8);
    report_and_stop();
  end
endmodule // tb_top
